//--- logic/msdt_pkg.sv
// Operation
// - Sleep with bits 0,0,0 and direct starts high-speed transition
// - High-speed entry passes sleep, waits for interrupt
// - Sleep with standby, low, watch timer and direct bits 1 starts subactive transition
// - Subactive entry passes watch mode first
// - 2+1 states old clock, 14 states new clock
package msdt_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] MSDT_REG_ONE_ADDR = 12'h000;
	localparam logic [11:0] MSDT_REG_TWO_ADDR = 12'h004;
	localparam logic [11:0] MSDT_STATUS_ADDR = 12'h008;
	localparam logic [11:0] MSDT_COUNT_ADDR = 12'h00c;

	// Control register one fields
	localparam int MSDT_STANDBY_POS = 0;
	localparam int MSDT_LOW_SPEED_POS = 1;
	localparam int MSDT_WATCH_TIMER_POS = 2;
	// Control register two fields
	localparam int MSDT_MEDIUM_SPEED_POS = 0;
	localparam int MSDT_DIRECT_POS = 1;

	localparam logic [2:0] MSDT_REG_ONE_RESET = 3'h0;
	localparam logic [1:0] MSDT_REG_TWO_RESET = 2'h0;

	// ****************************************
	// Timing counts, in states
	// ****************************************
	localparam int MSDT_SLEEP_STATES = 2;
	localparam int MSDT_INTERNAL_STATES = 1;
	localparam int MSDT_EXCEPTION_STATES = 14;
	localparam int MSDT_PRE_STATES = MSDT_SLEEP_STATES + MSDT_INTERNAL_STATES;

	typedef enum logic [5:0] {
		MSDT_MEDIUM = 6'b000001,
		MSDT_PRE = 6'b000010,
		MSDT_SLEEP = 6'b000100,
		MSDT_WATCH = 6'b001000,
		MSDT_EXC = 6'b010000,
		MSDT_DONE = 6'b100000
	} msdt_state_type;

	typedef enum logic [1:0] {
		MSDT_MODE_MEDIUM = 2'h0,
		MSDT_MODE_HIGH = 2'h1,
		MSDT_MODE_SUB = 2'h2
	} msdt_mode_type;

	typedef struct packed {
		logic [2:0] regOne;
		logic [1:0] regTwo;
	} msdt_ctrl_type;

endpackage

//--- logic/msdt_state_counter.sv
`timescale 1ns/100ps
module msdt_state_counter
	import msdt_pkg::*;
#(
	parameter int WIDTH = 5
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	input wire logic tick,
	output logic zero
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (load) begin
			count_next = loadValue;
		end else if (tick && count_reg != '0) begin
			count_next = count_reg - WIDTH'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign zero = (count_reg == '0);
endmodule // msdt_state_counter

//--- logic/msdt_controller.sv
`timescale 1ns/100ps
module msdt_controller
	import msdt_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleepExec,
	input wire logic interruptReq,
	input wire logic oldClockTick,
	input wire logic newClockTick,
	output logic [1:0] cpuMode,
	output logic sleepActive,
	output logic watchActive,
	output logic transitionDone
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		msdt_ctrl_type ctrl;
		msdt_state_type state;
		logic toSub;
		msdt_mode_type mode;
		logic [31:0] rdata;
		logic done;
		logic [15:0] transitions;
	} msdt_all_type;

	// ****************************************
	// Signals
	// ****************************************
	msdt_all_type all_reg;
	msdt_all_type all_next;
	logic cntLoad;
	logic [4:0] cntValue;
	logic cntTick;
	logic cntZero;

	// ****************************************
	// Decoding
	// ****************************************
	function automatic logic isReg(input logic [11:0] a, input logic [11:0] b);
		return a == b;
	endfunction

	// High-speed path: standby, low and medium clear, direct set
	function automatic logic highPath(input msdt_ctrl_type c);
		return !c.regOne[MSDT_STANDBY_POS]
			&& !c.regOne[MSDT_LOW_SPEED_POS]
			&& !c.regTwo[MSDT_MEDIUM_SPEED_POS]
			&& c.regTwo[MSDT_DIRECT_POS];
	endfunction

	// Subactive path: standby, low, watch timer and direct set
	function automatic logic subPath(input msdt_ctrl_type c);
		return c.regOne[MSDT_STANDBY_POS]
			&& c.regOne[MSDT_LOW_SPEED_POS]
			&& c.regOne[MSDT_WATCH_TIMER_POS]
			&& c.regTwo[MSDT_DIRECT_POS];
	endfunction

	// Control bits after a bus write
	function automatic msdt_ctrl_type writeCtrl(
		input msdt_ctrl_type c,
		input logic [11:0] a,
		input logic [31:0] d
	);
		msdt_ctrl_type result;
		result = c;
		if (isReg(a, MSDT_REG_ONE_ADDR)) begin
			result.regOne = d[2:0];
		end else if (isReg(a, MSDT_REG_TWO_ADDR)) begin
			result.regTwo = d[1:0];
		end
		return result;
	endfunction

	// Read word, unmapped offsets read zero
	function automatic logic [31:0] readWord(
		input logic [11:0] a,
		input msdt_ctrl_type c,
		input msdt_mode_type m,
		input msdt_state_type s,
		input logic [15:0] t
	);
		logic [31:0] result;
		result = 32'h0;
		if (isReg(a, MSDT_REG_ONE_ADDR)) begin
			result = {29'h0, c.regOne};
		end else if (isReg(a, MSDT_REG_TWO_ADDR)) begin
			result = {30'h0, c.regTwo};
		end else if (isReg(a, MSDT_STATUS_ADDR)) begin
			result = {24'h0, 2'(m), s};
		end else if (isReg(a, MSDT_COUNT_ADDR)) begin
			result = {16'h0, t};
		end
		return result;
	endfunction

	// ****************************************
	// State counter
	// ****************************************
	msdt_state_counter #(
		.WIDTH(5)
	) stateCounter (
		.clock(clock),
		.srst(srst),
		.load(cntLoad),
		.loadValue(cntValue),
		.tick(cntTick),
		.zero(cntZero)
	);

	wire logic access = psel && penable;
	// Path selects from the live control bits
	wire logic goHigh = highPath(all_reg.ctrl);
	wire logic goSub = subPath(all_reg.ctrl);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		all_next = all_reg;
		all_next.done = 1'b0;
		cntLoad = 1'b0;
		cntValue = 5'(MSDT_PRE_STATES);
		cntTick = 1'b0;

		// ****************************************
		// Bus access
		// ****************************************
		if (access && pwrite) begin
			all_next.ctrl = writeCtrl(all_reg.ctrl, paddr, pwdata);
		end

		if (psel && !penable) begin
			all_next.rdata = readWord(
				paddr,
				all_reg.ctrl,
				all_reg.mode,
				all_reg.state,
				all_reg.transitions
			);
		end
		// ****************************************
		// Transition sequence
		// ****************************************
		case (all_reg.state)
			MSDT_MEDIUM: begin
				if (sleepExec && all_reg.mode == MSDT_MODE_MEDIUM && (goHigh || goSub)) begin
					all_next.toSub = goSub;
					all_next.state = MSDT_PRE;
					cntLoad = 1'b1;
				end
			end
			MSDT_PRE: begin
				cntTick = oldClockTick;
				if (cntZero) begin
					all_next.state = all_reg.toSub ? MSDT_WATCH : MSDT_SLEEP;
				end
			end
			MSDT_SLEEP, MSDT_WATCH: begin
				if (interruptReq) begin
					all_next.mode = all_reg.toSub ? MSDT_MODE_SUB : MSDT_MODE_HIGH;
					all_next.state = MSDT_EXC;
					cntLoad = 1'b1;
					cntValue = 5'(MSDT_EXCEPTION_STATES);
				end
			end
			MSDT_EXC: begin
				cntTick = newClockTick;
				if (cntZero) begin
					all_next.state = MSDT_DONE;
				end
			end
			MSDT_DONE: begin
				all_next.done = 1'b1;
				all_next.transitions = all_reg.transitions + 16'h1;
				all_next.state = MSDT_MEDIUM;
			end
			default: begin
				all_next.state = MSDT_MEDIUM;
			end
		endcase
	end

	// ****************************************
	// Register update
	// ****************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			all_reg.ctrl.regOne <= MSDT_REG_ONE_RESET;
			all_reg.ctrl.regTwo <= MSDT_REG_TWO_RESET;
			all_reg.state <= MSDT_MEDIUM;
			all_reg.toSub <= 1'b0;
			all_reg.mode <= MSDT_MODE_MEDIUM;
			all_reg.rdata <= 32'h0;
			all_reg.done <= 1'b0;
			all_reg.transitions <= 16'h0;
		end else begin
			all_reg <= all_next;
		end
	end

	// ****************************************
	// Bus outputs
	// ****************************************
	assign prdata = all_reg.rdata;
	assign pready = psel && penable;
	assign pslverr = 1'b0;
	// ****************************************
	// Mode outputs
	// ****************************************
	assign cpuMode = all_reg.mode;
	assign sleepActive = (all_reg.state == MSDT_SLEEP);
	assign watchActive = (all_reg.state == MSDT_WATCH);
	assign transitionDone = all_reg.done;
endmodule // msdt_controller

//--- verif/msdt_checker.sv
`timescale 1ns/100ps
module msdt_checker(
	input wire logic clock,
	input wire logic srst,
	input wire logic interruptReq,
	input wire logic oldClockTick,
	input wire logic [1:0] cpuMode,
	input wire logic sleepActive,
	input wire logic watchActive,
	input wire logic transitionDone
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	mode_cause_a: assert property ($changed(cpuMode) |-> $past(interruptReq) && $past(sleepActive || watchActive))
		else $error("mode changed without wake");
	stay_medium_a: assert property (sleepActive || watchActive |-> cpuMode == 2'h0)
		else $error("mode left medium before wake");
	one_path_a: assert property (!(sleepActive && watchActive))
		else $error("sleep and watch together");
	old_ticks_a: assert property ($rose(sleepActive || watchActive) |-> $past(oldClockTick) || $past(oldClockTick, 2))
		else $error("entry not on old tick");
	exc_span_a: assert property ($changed(cpuMode) |-> !transitionDone [*8] ##[1:300] transitionDone)
		else $error("exception span wrong");
	done_pulse_a: assert property (transitionDone |=> !transitionDone)
		else $error("done longer than one cycle");
	cover property ($rose(sleepActive));
	cover property ($rose(watchActive));
	cover property (transitionDone);
endmodule // msdt_checker
bind msdt_controller msdt_checker u_chk(
	.clock(clock),
	.srst(srst),
	.interruptReq(interruptReq),
	.oldClockTick(oldClockTick),
	.cpuMode(cpuMode),
	.sleepActive(sleepActive),
	.watchActive(watchActive),
	.transitionDone(transitionDone)
);

//--- verif/msdt_cpu_model.sv
`timescale 1ns/100ps
module msdt_cpu_model(
	input wire logic clock,
	input wire logic doSleep,
	input wire logic doIrq,
	output logic sleepExec = 1'b0,
	output logic interruptReq = 1'b0,
	output logic oldClockTick = 1'b0,
	output logic newClockTick = 1'b0
);
	logic [2:0] phaseReg = 3'h0;
	// Old tick every 2 cycles, new tick every 8
	always @(posedge clock) begin
		phaseReg <= phaseReg + 3'h1;
		oldClockTick <= phaseReg[0];
		newClockTick <= (phaseReg == 3'h5);
		sleepExec <= doSleep;
		interruptReq <= doIrq;
	end
endmodule // msdt_cpu_model

//--- verif/medium_speed_direct_mode_transition_tb.sv
`timescale 1ns/100ps
module medium_speed_direct_mode_transition_tb;
	import msdt_pkg::*;
	logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, doSleep = 0, doIrq = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, sleepExec, interruptReq, oldClockTick, newClockTick;
	logic sleepActive, watchActive, transitionDone;
	logic [1:0] cpuMode;
	int miscompares = 0, tests_run = 0, n;
	always #25 clock = ~clock;
	msdt_controller DUT(
		.clock(clock),
		.srst(srst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sleepExec(sleepExec),
		.interruptReq(interruptReq),
		.oldClockTick(oldClockTick),
		.newClockTick(newClockTick),
		.cpuMode(cpuMode),
		.sleepActive(sleepActive),
		.watchActive(watchActive),
		.transitionDone(transitionDone)
	);
	msdt_cpu_model cpu(
		.clock(clock),
		.doSleep(doSleep),
		.doIrq(doIrq),
		.sleepExec(sleepExec),
		.interruptReq(interruptReq),
		.oldClockTick(oldClockTick),
		.newClockTick(newClockTick)
	);
	task chk(input logic ok);
		tests_run++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: value mismatch", $time);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		chk(pslverr === 1'b0);
		psel <= 0;
		penable <= 0;
	endtask
	task restart;
		srst <= 1;
		repeat (10) @(posedge clock);
		srst <= 0;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task regs;
		apb(0, MSDT_REG_TWO_ADDR, 0);
		chk(rd[1:0] === MSDT_REG_TWO_RESET);
		apb(1, MSDT_REG_ONE_ADDR, 32'h5);
		apb(0, MSDT_REG_ONE_ADDR, 0);
		chk(rd[2:0] === 3'h5);
		apb(1, 12'h010, 32'hff);
		apb(0, 12'h010, 0);
		chk(rd === 32'h0);
	endtask
	task refused(input logic [2:0] r1, input logic [1:0] r2);
		restart;
		apb(1, MSDT_REG_ONE_ADDR, {29'h0, r1});
		apb(1, MSDT_REG_TWO_ADDR, {30'h0, r2});
		doSleep <= 1;
		@(posedge clock);
		doSleep <= 0;
		repeat (40) @(posedge clock);
		chk(sleepActive === 1'b0 && watchActive === 1'b0 && cpuMode === MSDT_MODE_MEDIUM);
	endtask
	task trans(input logic [2:0] r1, input logic [1:0] r2, input msdt_mode_type m);
		restart;
		apb(1, MSDT_REG_ONE_ADDR, {29'h0, r1});
		apb(1, MSDT_REG_TWO_ADDR, {30'h0, r2});
		doSleep <= 1;
		@(posedge clock);
		doSleep <= 0;
		for (n = 0; n < 40 && (m == MSDT_MODE_HIGH ? sleepActive : watchActive) !== 1'b1; n++) @(posedge clock);
		chk(n >= 2 * MSDT_PRE_STATES && n <= 2 * MSDT_PRE_STATES + 4 && cpuMode === MSDT_MODE_MEDIUM);
		doIrq <= 1;
		for (n = 0; n < 300 && transitionDone !== 1'b1; n++) @(posedge clock);
		doIrq <= 0;
		chk(n >= MSDT_EXCEPTION_STATES * 8 - 8 && n <= MSDT_EXCEPTION_STATES * 8 + 16 && cpuMode === m);
		apb(0, MSDT_STATUS_ADDR, 0);
		chk(rd === {24'h0, m, MSDT_MEDIUM});
		apb(0, MSDT_COUNT_ADDR, 0);
		chk(rd === 32'h1);
		doSleep <= 1;
		@(posedge clock);
		doSleep <= 0;
		repeat (20) @(posedge clock);
		chk(sleepActive === 1'b0 && watchActive === 1'b0 && cpuMode === m);
	endtask
	task complete_run;
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		miscompares++;
		complete_run;
	end
	initial begin
		restart;
		regs;
		trans(3'h0, 2'h2, MSDT_MODE_HIGH);
		trans(3'h7, 2'h2, MSDT_MODE_SUB);
		refused(3'h0, 2'h3);
		refused(3'h3, 2'h2);
		complete_run;
	end
endmodule // medium_speed_direct_mode_transition_tb
